/* cfd_pkg.sv */
// Shared constants for the current fault delay timer
package cfd_pkg;
   // Clock and counter geometry
   localparam int CLK_PERIOD_NS = 100;
   localparam int CODE_W = 4;
   localparam int CNT_W = 19;
   localparam int NUM_CHAN = 4;
   // Channel indices
   localparam int CH_DOC = 0;
   localparam int CH_SCC = 1;
   localparam int CH_DS1 = 2;
   localparam int CH_DS2 = 3;
   // Programmed times, in their own units
   localparam int DOC_BASE_MS = 1;
   localparam int DOC_STEP_US = 2000;
   localparam int DOC_MAX_MS = 31;
   localparam int SCC_STEP_US = 61;
   localparam int DS1_STEP_US = 61;
   localparam int DS1_STEP_X2_US = 121;
   localparam int DS2_STEP_NS = 30500;
   localparam int DS2_STEP_X2_US = 61;
   localparam int DETECT_MAX_US = 160;
   localparam int ACC_PCT = 10;
   // Derived cycle counts
   localparam int DOC_BASE_CYC = DOC_BASE_MS * 1000 * 1000 / CLK_PERIOD_NS;
   localparam int DOC_STEP_CYC = DOC_STEP_US * 1000 / CLK_PERIOD_NS;
   localparam int DOC_MAX_CYC = DOC_MAX_MS * 1000 * 1000 / CLK_PERIOD_NS;
   localparam int SCC_STEP_CYC = SCC_STEP_US * 1000 / CLK_PERIOD_NS;
   localparam int DS1_STEP_CYC = DS1_STEP_US * 1000 / CLK_PERIOD_NS;
   localparam int DS1_STEP_X2_CYC = DS1_STEP_X2_US * 1000 / CLK_PERIOD_NS;
   localparam int DS2_STEP_CYC = DS2_STEP_NS / CLK_PERIOD_NS;
   localparam int DS2_STEP_X2_CYC = DS2_STEP_X2_US * 1000 / CLK_PERIOD_NS;
   localparam int DETECT_MAX_CYC = DETECT_MAX_US * 1000 / CLK_PERIOD_NS;
   localparam int DOC_ACC_LO_CYC = DOC_MAX_CYC * (100 - ACC_PCT) / 100;
   localparam int DOC_ACC_HI_CYC = DOC_MAX_CYC * (100 + ACC_PCT) / 100;
   // Reset values
   localparam logic [CNT_W-1:0] CNT_RESET = 19'h00000;
   localparam logic FAULT_RESET = 1'b0;
endpackage

/* cfd_chan_if.sv */
// Carrier between the top and one delay channel
`timescale 1ns/10ps
`default_nettype none
interface cfd_chan_if;
   logic active;
   logic clear;
   logic [cfd_pkg::CNT_W-1:0] limit;
   logic fault;
   // Top drives condition and limit, channel returns fault
   modport ctrl (output active, output clear, output limit, input fault);
   modport chan (input active, input clear, input limit, output fault);
endinterface
`default_nettype wire

/* cfd_delay_chan.sv */
// One fault delay channel: qualifies a condition over a programmed time
`timescale 1ns/10ps
`default_nettype none
module cfd_delay_chan (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   cfd_chan_if.chan ch
);
   logic [cfd_pkg::CNT_W-1:0] cnt_q;
   logic [cfd_pkg::CNT_W-1:0] cnt_d;
   logic fault_q;
   logic fault_d;
   wire [cfd_pkg::CNT_W:0] cnt_next_w;
   wire reached_w;

   // Delay expires once the held time reaches the limit
   assign cnt_next_w = {1'b0, cnt_q} + {{cfd_pkg::CNT_W{1'b0}}, 1'b1};
   assign reached_w = ch.active && (cnt_next_w >= {1'b0, ch.limit});
   // Dropout restarts timing, so a glitch never adds up
   assign cnt_d = !ch.active ? cfd_pkg::CNT_RESET :
                  reached_w ? cnt_q : cnt_next_w[cfd_pkg::CNT_W-1:0];
   // New fault wins over a clear in the same cycle
   assign fault_d = reached_w | (fault_q & ~ch.clear);
   assign ch.fault = fault_q;

   // Counter and latched fault
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         cnt_q <= cfd_pkg::CNT_RESET;
         fault_q <= cfd_pkg::FAULT_RESET;
      end else begin
         cnt_q <= cnt_d;
         fault_q <= fault_d;
      end
   end

   property p_drop_no_fault;
      @(posedge i_ref_clk) disable iff (i_reset)
      (!ch.active && !fault_q) |=> !fault_q;
   endproperty
   a_drop_no_fault: assert property (p_drop_no_fault)
      else $error("fault raised while condition absent");

   property p_drop_restart;
      @(posedge i_ref_clk) disable iff (i_reset)
      (ch.active && !reached_w ##1 !ch.active) |=> (cnt_q == 0);
   endproperty
   a_drop_restart: assert property (p_drop_restart)
      else $error("delay count not restarted after dropout");

   property p_fault_sticky;
      @(posedge i_ref_clk) disable iff (i_reset)
      (fault_q && !ch.clear) |=> fault_q [*1];
   endproperty
   a_fault_sticky: assert property (p_fault_sticky)
      else $error("fault lost without clear");
endmodule
`default_nettype wire

/* cfd_current_fault_delay_timer.sv */
// Current fault delay timer top: synchronisers, delay limits, four channels
`timescale 1ns/10ps
`default_nettype none
module cfd_current_fault_delay_timer #(
   parameter int DOC_BASE_CYC = cfd_pkg::DOC_BASE_CYC,
   parameter int DOC_STEP_CYC = cfd_pkg::DOC_STEP_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_discharge_overcurrent_cmp,
   input wire logic i_charge_short_cmp,
   input wire logic i_discharge_short_level_one_cmp,
   input wire logic i_discharge_short_level_two_cmp,
   input wire logic [cfd_pkg::CODE_W-1:0] i_discharge_overcurrent_code,
   input wire logic [cfd_pkg::CODE_W-1:0] i_charge_short_code,
   input wire logic [cfd_pkg::CODE_W-1:0] i_discharge_short_level_one_code,
   input wire logic [cfd_pkg::CODE_W-1:0] i_discharge_short_level_two_code,
   input wire logic i_short_delay_doubling,
   input wire logic i_fault_clear,
   output logic o_discharge_overcurrent_fault,
   output logic o_charge_short_fault,
   output logic o_discharge_short_level_one_fault,
   output logic o_discharge_short_level_two_fault,
   output logic o_fault_any
);
   localparam int NC = cfd_pkg::NUM_CHAN;
   localparam int CW = cfd_pkg::CNT_W;

   typedef logic [CW-1:0] cfd_limit_type;

   // Limit in cycles: base plus code times step
   function automatic cfd_limit_type cfd_limit(
      input int base,
      input int step,
      input logic [cfd_pkg::CODE_W-1:0] code
   );
      int prod;
      prod = base + step * int'(code);
      cfd_limit = CW'(prod);
   endfunction

   logic [NC-1:0] cmp_raw_w;
   logic [NC-1:0] sync1_q;
   logic [NC-1:0] sync2_q;
   cfd_limit_type limit_q [NC];
   cfd_limit_type limit_d [NC];
   logic [NC-1:0] fault_w;
   wire [31:0] ds1_step_w;
   wire [31:0] ds2_step_w;

   assign cmp_raw_w[cfd_pkg::CH_DOC] = i_discharge_overcurrent_cmp;
   assign cmp_raw_w[cfd_pkg::CH_SCC] = i_charge_short_cmp;
   assign cmp_raw_w[cfd_pkg::CH_DS1] = i_discharge_short_level_one_cmp;
   assign cmp_raw_w[cfd_pkg::CH_DS2] = i_discharge_short_level_two_cmp;

   // Comparators are analog and asynchronous, so two flops first
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end else begin
         sync1_q <= cmp_raw_w;
         sync2_q <= sync1_q;
      end
   end

   // Step size of the discharge short channels follows the doubling bit
   assign ds1_step_w = i_short_delay_doubling ?
                       cfd_pkg::DS1_STEP_X2_CYC : cfd_pkg::DS1_STEP_CYC;
   assign ds2_step_w = i_short_delay_doubling ?
                       cfd_pkg::DS2_STEP_X2_CYC : cfd_pkg::DS2_STEP_CYC;
   // Exact cycle multiples keep every setting well inside the tolerance
   assign limit_d[cfd_pkg::CH_DOC] = cfd_limit(DOC_BASE_CYC, DOC_STEP_CYC,
                                     i_discharge_overcurrent_code);
   assign limit_d[cfd_pkg::CH_SCC] = cfd_limit(0, cfd_pkg::SCC_STEP_CYC,
                                     i_charge_short_code);
   assign limit_d[cfd_pkg::CH_DS1] = cfd_limit(0, int'(ds1_step_w),
                                     i_discharge_short_level_one_code);
   assign limit_d[cfd_pkg::CH_DS2] = cfd_limit(0, int'(ds2_step_w),
                                     i_discharge_short_level_two_code);

   // Registered limits cut the multiplier off the counter compare path
   always_ff @(posedge i_ref_clk) begin
      for (int i = 0; i < NC; i++) begin
         if (i_reset) begin
            limit_q[i] <= cfd_pkg::CNT_RESET;
         end else begin
            limit_q[i] <= limit_d[i];
         end
      end
   end

   // One delay channel per protection comparator
   for (genvar g = 0; g < NC; g++) begin : g_chan
      cfd_chan_if u_if ();
      assign u_if.active = sync2_q[g];
      assign u_if.clear = i_fault_clear;
      assign u_if.limit = limit_q[g];
      assign fault_w[g] = u_if.fault;
      cfd_delay_chan u_chan (
         .i_ref_clk(i_ref_clk),
         .i_reset(i_reset),
         .ch(u_if.chan)
      );
   end

   // Channel faults come straight from channel flops, o_fault_any is their OR
   assign o_discharge_overcurrent_fault = fault_w[cfd_pkg::CH_DOC];
   assign o_charge_short_fault = fault_w[cfd_pkg::CH_SCC];
   assign o_discharge_short_level_one_fault = fault_w[cfd_pkg::CH_DS1];
   assign o_discharge_short_level_two_fault = fault_w[cfd_pkg::CH_DS2];
   assign o_fault_any = |fault_w;

   property p_doc_limit;
      @(posedge i_ref_clk) disable iff (i_reset)
      1'b1 |=> limit_q[cfd_pkg::CH_DOC] == CW'(DOC_BASE_CYC +
               DOC_STEP_CYC * int'($past(i_discharge_overcurrent_code)));
   endproperty
   a_doc_limit: assert property (p_doc_limit)
      else $error("overcurrent delay limit wrong");

   property p_scc_limit;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_charge_short_code == 4'hf) |=> limit_q[cfd_pkg::CH_SCC] ==
         CW'(15 * cfd_pkg::SCC_STEP_CYC);
   endproperty
   a_scc_limit: assert property (p_scc_limit)
      else $error("charge short maximum delay wrong");

   property p_scd_double;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_short_delay_doubling && i_discharge_short_level_one_code == 4'h1 &&
       i_discharge_short_level_two_code == 4'h1) |=>
      (limit_q[cfd_pkg::CH_DS1] == CW'(cfd_pkg::DS1_STEP_X2_CYC) &&
       limit_q[cfd_pkg::CH_DS2] == CW'(cfd_pkg::DS2_STEP_X2_CYC));
   endproperty
   a_scd_double: assert property (p_scd_double)
      else $error("doubled short delay step wrong");

   property p_scd_single;
      @(posedge i_ref_clk) disable iff (i_reset)
      (!i_short_delay_doubling && i_discharge_short_level_two_code == 4'h2)
      |=> limit_q[cfd_pkg::CH_DS2] == CW'(2 * cfd_pkg::DS2_STEP_CYC);
   endproperty
   a_scd_single: assert property (p_scd_single)
      else $error("single short level two delay wrong");

   sequence s_scc_held;
      (i_charge_short_cmp && i_charge_short_code == 4'h0) [*4];
   endsequence
   property p_detect;
      @(posedge i_ref_clk) disable iff (i_reset)
      s_scc_held |-> o_charge_short_fault;
   endproperty
   a_detect: assert property (p_detect)
      else $error("charge short not recognised in time");

   // Cycles the overcurrent channel has been qualifying
   logic [CW-1:0] doc_held_q;
   always_ff @(posedge i_ref_clk) begin
      if (i_reset || !sync2_q[cfd_pkg::CH_DOC]) begin
         doc_held_q <= cfd_pkg::CNT_RESET;
      end else if (!o_discharge_overcurrent_fault) begin
         doc_held_q <= doc_held_q + 19'h00001;
      end
   end

   property p_doc_accuracy;
      @(posedge i_ref_clk) disable iff (i_reset)
      ($rose(o_discharge_overcurrent_fault) &&
       $past(i_discharge_overcurrent_code) == 4'hf &&
       DOC_BASE_CYC == cfd_pkg::DOC_BASE_CYC &&
       DOC_STEP_CYC == cfd_pkg::DOC_STEP_CYC) |->
      (int'(doc_held_q) >= cfd_pkg::DOC_ACC_LO_CYC &&
       int'(doc_held_q) <= cfd_pkg::DOC_ACC_HI_CYC);
   endproperty
   a_doc_accuracy: assert property (p_doc_accuracy)
      else $error("maximum overcurrent delay out of tolerance");
endmodule
`default_nettype wire

/* tb_cfd_current_fault_delay_timer.sv */
// Self-checking bench for the current fault delay timer
`timescale 1ns/10ps
`default_nettype none
module tb_cfd_current_fault_delay_timer;
   // Shortened overcurrent counts keep the run brief
   localparam int OB = 10;
   localparam int OS = 20;
   localparam int SC = cfd_pkg::SCC_STEP_CYC;
   localparam int S1 = cfd_pkg::DS1_STEP_CYC;
   localparam int S1X = cfd_pkg::DS1_STEP_X2_CYC;
   localparam int S2 = cfd_pkg::DS2_STEP_CYC;
   localparam int S2X = cfd_pkg::DS2_STEP_X2_CYC;
   typedef struct {
      int ch;
      logic [3:0] cd;
      logic dx;
      int lim;
   } cfd_row_type;
   // Channel, code, doubling, expected limit in cycles
   cfd_row_type rows [11] = '{
      '{0, 4'h0, 1'b0, OB}, '{0, 4'hf, 1'b0, OB + 15 * OS},
      '{1, 4'h0, 1'b0, 0}, '{1, 4'h1, 1'b0, SC}, '{1, 4'hf, 1'b0, 15 * SC},
      '{2, 4'h1, 1'b0, S1}, '{2, 4'h1, 1'b1, S1X}, '{2, 4'hf, 1'b1, 15 * S1X},
      '{3, 4'h1, 1'b0, S2}, '{3, 4'h1, 1'b1, S2X}, '{3, 4'hf, 1'b0, 15 * S2}};
   logic i_ref_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [3:0] cmp = 4'h0;
   logic [3:0] code [4] = '{default: 4'h0};
   logic dbl = 1'b0;
   logic clr = 1'b0;
   logic [3:0] flt;
   logic any;
   int num_errors = 0;
   int comparisons = 0;
   int n;
   int exp_n;

   cfd_current_fault_delay_timer #(
      .DOC_BASE_CYC(OB),
      .DOC_STEP_CYC(OS)
   ) dut_u (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_discharge_overcurrent_cmp(cmp[0]),
      .i_charge_short_cmp(cmp[1]),
      .i_discharge_short_level_one_cmp(cmp[2]),
      .i_discharge_short_level_two_cmp(cmp[3]),
      .i_discharge_overcurrent_code(code[0]),
      .i_charge_short_code(code[1]),
      .i_discharge_short_level_one_code(code[2]),
      .i_discharge_short_level_two_code(code[3]),
      .i_short_delay_doubling(dbl),
      .i_fault_clear(clr),
      .o_discharge_overcurrent_fault(flt[0]),
      .o_charge_short_fault(flt[1]),
      .o_discharge_short_level_one_fault(flt[2]),
      .o_discharge_short_level_two_fault(flt[3]),
      .o_fault_any(any)
   );

   // Free-running reference clock
   always #50 i_ref_clk = ~i_ref_clk;

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] seen);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      if (num_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Raise one comparator and count edges until its fault shows
   task automatic time_fault(input int ch, input int bound, output int cnt);
      cnt = 0;
      cmp[ch] = 1'b1;
      while (flt[ch] !== 1'b1 && cnt < bound + 8) begin
         @(negedge i_ref_clk);
         cnt++;
      end
      if (flt[ch] !== 1'b1) begin
         num_errors++;
         print_verdict();
      end
   endtask

   // Drop the condition, let the synchroniser drain, then clear
   task automatic release_clear(input int ch);
      cmp[ch] = 1'b0;
      repeat (4) @(negedge i_ref_clk);
      check("fault held", 32'h1, {31'h0, flt[ch]});
      clr = 1'b1;
      @(negedge i_ref_clk);
      clr = 1'b0;
      check("fault cleared", 32'h0, {28'h0, flt});
   endtask

   initial begin
      repeat (3) @(negedge i_ref_clk);
      i_reset = 1'b0;
      check("faults after reset", 32'h0, {27'h0, any, flt});
      // Table of delays: every channel, both doubling settings on the two discharge short channels
      foreach (rows[i]) begin
         code[rows[i].ch] = rows[i].cd;
         dbl = rows[i].dx;
         repeat (2) @(negedge i_ref_clk);
         exp_n = 2 + ((rows[i].lim < 1) ? 1 : rows[i].lim);
         time_fault(rows[i].ch, exp_n, n);
         check("fault delay", exp_n, n);
         check("fault any", 32'h1, {31'h0, any});
         check("one fault", 32'h1 << rows[i].ch, {28'h0, flt});
         release_clear(rows[i].ch);
      end
      // Dropout before expiry gives no fault, retiming starts from zero
      code[1] = 4'h2;
      @(negedge i_ref_clk);
      cmp[1] = 1'b1;
      repeat (600) @(negedge i_ref_clk);
      cmp[1] = 1'b0;
      repeat (1300) @(negedge i_ref_clk);
      check("no fault after dropout", 32'h0, {27'h0, any, flt});
      time_fault(1, 2 + 2 * SC, n);
      check("delay after dropout", 2 + 2 * SC, n);
      release_clear(1);
      // A clear while the condition stands loses to the new expiry
      code[1] = 4'h0;
      @(negedge i_ref_clk);
      time_fault(1, 3, n);
      check("delay code zero", 3, n);
      clr = 1'b1;
      @(negedge i_ref_clk);
      clr = 1'b0;
      check("set wins over clear", 32'h1, {31'h0, flt[1]});
      release_clear(1);
      // Reset in mid-run drops a latched fault
      code[0] = 4'h0;
      @(negedge i_ref_clk);
      time_fault(0, 2 + OB, n);
      check("delay before second reset", 2 + OB, n);
      cmp[0] = 1'b0;
      i_reset = 1'b1;
      @(negedge i_ref_clk);
      i_reset = 1'b0;
      check("faults after second reset", 32'h0, {27'h0, any, flt});
      print_verdict();
   end
endmodule
`default_nettype wire
